// ---- spg_map.svh ----
// Offsets, field positions, reset values and timing counts of the sector guard
`ifndef SPG_MAP_SVH
`define SPG_MAP_SVH

// ----------------------------------------------------------------------------
// Guard byte words as seen from the two-wire side (chip enable select bit = 1)
// ----------------------------------------------------------------------------
`define SPG_GUARD_WORD_0_OFFSET 11'h000
`define SPG_GUARD_WORD_1_OFFSET 11'h004
`define SPG_GUARD_WORD_2_OFFSET 11'h008
`define SPG_GUARD_WORD_3_OFFSET 11'h00c
`define SPG_GUARD_AREA_BYTES    16

// ----------------------------------------------------------------------------
// Guard byte fields
// ----------------------------------------------------------------------------
`define SPG_GUARD_LOCK_BIT 0
`define SPG_GUARD_CODE_MSB 2
`define SPG_GUARD_CODE_LSB 1
`define SPG_GUARD_LINK_MSB 4
`define SPG_GUARD_LINK_LSB 3
`define SPG_GUARD_RESET    8'h00

// ----------------------------------------------------------------------------
// Password slots and block layout
// ----------------------------------------------------------------------------
`define SPG_PWD_RESET        32'h0000_0000
`define SPG_BLOCK_SHIFT      5
`define SPG_BYTE_ADDR_SHIFT  2

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define SPG_CLK_PERIOD_NS   100
`define SPG_NV_WRITE_NS     5750000
`define SPG_NV_WRITE_CYCLES ((`SPG_NV_WRITE_NS + `SPG_CLK_PERIOD_NS - 1) / `SPG_CLK_PERIOD_NS)

`endif

// ---- spg_pkg.sv ----
// Types shared by the sector guard modules
package spg_pkg;

  // --------------------------------------------------------------------------
  // Contactless command codes
  // --------------------------------------------------------------------------
  typedef enum logic [2:0] {
    SPG_OP_READ,
    SPG_OP_WRITE,
    SPG_OP_LOCK,
    SPG_OP_PWD_WRITE,
    SPG_OP_PWD_PRESENT
  } spg_rf_op_t;

  // --------------------------------------------------------------------------
  // Controller states
  // --------------------------------------------------------------------------
  typedef enum logic {
    SPG_ST_IDLE,
    SPG_ST_PWD_WAIT
  } spg_state_t;

  typedef logic [31:0] spg_word_t;

endpackage

// ---- spg_pwd_if.sv ----
// Link between the guard controller and the password store
`timescale 1ns/1ps
interface spg_pwd_if;
  import spg_pkg::*;
  logic        wr_start;
  logic [1:0]  wr_slot;
  spg_word_t   wr_data;
  logic        wr_done;
  logic        busy;
  spg_word_t   value [1:3];

  modport store (input wr_start, input wr_slot, input wr_data,
                 output wr_done, output busy, output value);
  modport ctrl  (output wr_start, output wr_slot, output wr_data,
                 input wr_done, input busy, input value);
endinterface

// ---- spg_pwd_store.sv ----
// Three password slots with a timed nonvolatile write
`timescale 1ns/1ps
module spg_pwd_store
  import spg_pkg::*;
#(
  parameter int unsigned NV_WRITE_CYCLES = 57500
)
(
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // Controller side
  spg_pwd_if.store  pif
);
  `include "spg_map.svh"

  localparam int unsigned CW = $clog2(NV_WRITE_CYCLES + 1);

  spg_word_t   slot_reg [1:3];
  spg_word_t   slot_next [1:3];
  logic        busy_reg, busy_next;
  logic        done_reg, done_next;
  logic [1:0]  wslot_reg, wslot_next;
  spg_word_t   wdata_reg, wdata_next;
  logic [CW-1:0] cnt_reg, cnt_next;

  // Old value stays in use until the write time has fully elapsed
  always_comb begin
    slot_next  = slot_reg;
    busy_next  = busy_reg;
    done_next  = 1'b0;
    wslot_next = wslot_reg;
    wdata_next = wdata_reg;
    cnt_next   = cnt_reg;
    if (busy_reg) begin
      if (cnt_reg == CW'(1)) begin
        busy_next = 1'b0;
        done_next = 1'b1;
        slot_next[wslot_reg] = wdata_reg;
      end
      cnt_next = cnt_reg - CW'(1);
    end else if (pif.wr_start) begin
      busy_next  = 1'b1;
      wslot_next = pif.wr_slot;
      wdata_next = pif.wr_data;
      cnt_next   = CW'(NV_WRITE_CYCLES);
    end
  end

  // Slots power up at zero and active
  always_ff @(posedge clk) begin
    if (rst) begin
      for (int i = 1; i <= 3; i++) begin
        slot_reg[i] <= `SPG_PWD_RESET;
      end
      busy_reg  <= 1'b0;
      done_reg  <= 1'b0;
      wslot_reg <= 2'd1;
      wdata_reg <= `SPG_PWD_RESET;
      cnt_reg   <= '0;
    end else begin
      slot_reg  <= slot_next;
      busy_reg  <= busy_next;
      done_reg  <= done_next;
      wslot_reg <= wslot_next;
      wdata_reg <= wdata_next;
      cnt_reg   <= cnt_next;
    end
  end

  assign pif.busy    = busy_reg;
  assign pif.wr_done = done_reg;
  assign pif.value   = slot_reg;

  chk_store_busy_start: assert property (@(posedge clk) disable iff (rst)
    (pif.wr_start && !busy_reg) |=> busy_reg && !done_reg)
    else $error("password write did not start");
endmodule

// ---- spg_reader_model.sv ----
// Contactless reader and two-wire host model driving the sector guard
`timescale 1ns/1ps
module spg_reader_model
  import spg_pkg::*;
(
  // Clock
  input  wire logic   clk,
  // Contactless side
  output logic        rf_cmd_valid,
  output spg_rf_op_t  rf_cmd_op,
  output logic [8:0]  rf_block_addr,
  output logic        rf_option_flag,
  output logic [3:0]  rf_lock_sector,
  output logic [1:0]  rf_pwd_slot,
  output logic [31:0] rf_cmd_data,
  input  wire logic   rf_cmd_ready,
  input  wire logic   rf_rsp_valid,
  // Two-wire side
  output logic        i2c_req_valid,
  output logic        i2c_req_write,
  output logic        chip_enable_select_bit,
  output logic [10:0] i2c_byte_addr,
  output logic [7:0]  i2c_wdata,
  output logic        i2c_pwd_accepted,
  input  wire logic   i2c_rsp_valid
);
  // ---------------------------------------------------------------------------
  // Requests, launched just after a falling edge
  // ---------------------------------------------------------------------------
  initial begin
    {rf_cmd_valid, rf_block_addr, rf_option_flag, rf_lock_sector} = '0;
    {rf_pwd_slot, rf_cmd_data, i2c_req_valid, i2c_req_write} = '0;
    {chip_enable_select_bit, i2c_byte_addr, i2c_wdata, i2c_pwd_accepted} = '0;
    rf_cmd_op = SPG_OP_READ;
  end

  // Waits for idle, sends one command, then scrambles the released block address and data
  task automatic rf(input spg_rf_op_t op, input logic [8:0] a, input logic opt,
                    input logic [3:0] s, input logic [1:0] sl, input logic [31:0] d,
                    output bit seen);
    int n = 0;
    @(negedge clk);
    while (rf_cmd_ready !== 1'b1 && n < 64) begin
      @(negedge clk);
      n++;
    end
    rf_cmd_op = op;
    {rf_block_addr, rf_option_flag} = {a, opt};
    {rf_lock_sector, rf_pwd_slot, rf_cmd_data} = {s, sl, d};
    rf_cmd_valid = 1'b1;
    @(negedge clk);
    rf_cmd_valid = 1'b0;
    {rf_block_addr, rf_cmd_data} = ~{rf_block_addr, rf_cmd_data};
    // A password write answers only once the slow store finishes
    while (rf_rsp_valid !== 1'b1 && n < 64) begin
      @(negedge clk);
      n++;
    end
    seen = (rf_rsp_valid === 1'b1);
  endtask

  // One byte request; the host password state is a level kept afterwards
  task automatic i2c(input logic w, input logic ce, input logic [10:0] a,
                     input logic [7:0] d, input logic acc, output bit seen);
    @(negedge clk);
    {i2c_req_write, chip_enable_select_bit, i2c_byte_addr} = {w, ce, a};
    {i2c_wdata, i2c_pwd_accepted} = {d, acc};
    i2c_req_valid = 1'b1;
    @(negedge clk);
    i2c_req_valid = 1'b0;
    {i2c_byte_addr, i2c_wdata} = ~{i2c_byte_addr, i2c_wdata};
    seen = (i2c_rsp_valid === 1'b1);
  endtask
endmodule

// ---- spg_rights_decode.sv ----
// Read and write permission of one sector from its guard byte
`timescale 1ns/1ps
module spg_rights_decode
  import spg_pkg::*;
(
  // Sector state
  input  wire logic [7:0] guard,
  input  wire logic [3:1] presented,
  // Permissions
  output logic            rd_ok,
  output logic            wr_ok
);
  `include "spg_map.svh"

  logic [1:0] code;
  logic [1:0] link;
  logic       has_pwd;

  // Rights table for a locked sector; an unlinked sector never has a password
  always_comb begin
    code    = guard[`SPG_GUARD_CODE_MSB:`SPG_GUARD_CODE_LSB];
    link    = guard[`SPG_GUARD_LINK_MSB:`SPG_GUARD_LINK_LSB];
    has_pwd = (link != 2'b00) && presented[link];
    if (!guard[`SPG_GUARD_LOCK_BIT]) begin
      rd_ok = 1'b1;
      wr_ok = 1'b1;
    end else begin
      case (code)
        2'b00: begin
          rd_ok = 1'b1;
          wr_ok = has_pwd;
        end
        2'b01: begin
          rd_ok = 1'b1;
          wr_ok = 1'b1;
        end
        2'b10: begin
          rd_ok = has_pwd;
          wr_ok = has_pwd;
        end
        default: begin
          rd_ok = has_pwd;
          wr_ok = 1'b0;
        end
      endcase
    end
  end
endmodule

// ---- spg_sector_guard.sv ----
// Sector access guard: guard bytes, password state and contactless permissions
//
// How it works
// - One guard byte per sector: lock bit 0, code bits 2:1, link bits 4:3.
// - Reads with option flag set also return the sector guard byte.
// - All guard bytes reset to 00h, nothing locked or linked.
// - Unlocked sector is always read/write; locked one uses code and password.
// - Codes 00,01,10,11 give the locked rights with and without password.
// - Link 00 means no password; 01,10,11 pick password 1,2,3.
// - Three 32-bit password slots, numbered 1 to 3.
// - Password write stores the word and uses it once the write ends.
// - A password may only change after it was presented correctly.
// - All password slots reset to zero and are active.
// - Sector lock writes bits 4:1, forces bit 0, takes effect at once.
// - Locked sector cannot be relocked; the command gets an error.
// - Correct presentation grants with-password rights to the sectors linked to that password only.
// - Wrong presentation withdraws every granted password right.
// - Two-wire reads of guard bytes are always allowed.
// - Two-wire writes of guard bytes need the two-wire password accepted.
// - Guard bytes sit at addresses 0 to 15 with chip enable select set.
// - A two-wire guard write re-initialises that sector's access condition.
// - Each sector holds 32 blocks sharing one guard byte.
`timescale 1ns/1ps
module spg_sector_guard
  import spg_pkg::*;
#(
  parameter int unsigned NV_WRITE_CYCLES = 57500,
  parameter int unsigned SECTORS         = 16
)
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // Contactless command
  input  wire logic        rf_cmd_valid,
  input  wire spg_rf_op_t  rf_cmd_op,
  input  wire logic [8:0]  rf_block_addr,
  input  wire logic        rf_option_flag,
  input  wire logic [3:0]  rf_lock_sector,
  input  wire logic [1:0]  rf_pwd_slot,
  input  wire logic [31:0] rf_cmd_data,
  output logic             rf_cmd_ready,
  // Contactless answer
  output logic             rf_rsp_valid,
  output logic             rf_rsp_error,
  output logic             rf_rsp_guard_valid,
  output logic [7:0]       rf_rsp_guard_byte,
  output logic [10:0]      rf_mem_byte_addr,
  output logic             rf_mem_read,
  output logic             rf_mem_write,
  // Two-wire request
  input  wire logic        i2c_req_valid,
  input  wire logic        i2c_req_write,
  input  wire logic        chip_enable_select_bit,
  input  wire logic [10:0] i2c_byte_addr,
  input  wire logic [7:0]  i2c_wdata,
  input  wire logic        i2c_pwd_accepted,
  // Two-wire answer
  output logic             i2c_rsp_valid,
  output logic             i2c_rsp_refused,
  output logic [7:0]       i2c_rdata
);
  `include "spg_map.svh"

  // --------------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------------
  spg_state_t  state_reg, state_next;
  logic [7:0]  guard_reg [SECTORS];
  logic [7:0]  guard_next [SECTORS];
  logic [3:1]  pres_reg, pres_next;
  logic        ready_reg, ready_next;
  logic        rsp_valid_reg, rsp_valid_next;
  logic        rsp_error_reg, rsp_error_next;
  logic        gvalid_reg, gvalid_next;
  logic [7:0]  gbyte_reg, gbyte_next;
  logic [10:0] maddr_reg, maddr_next;
  logic        mrd_reg, mrd_next;
  logic        mwr_reg, mwr_next;
  logic        i2c_valid_reg, i2c_valid_next;
  logic        i2c_ref_reg, i2c_ref_next;
  logic [7:0]  i2c_rdata_reg, i2c_rdata_next;
  logic [SECTORS-1:0] rd_ok;
  logic [SECTORS-1:0] wr_ok;
  logic [3:0]  sector;
  logic        i2c_hit;
  logic        rf_take;

  spg_pwd_if pif ();

  // --------------------------------------------------------------------------
  // Password store and per-sector rights
  // --------------------------------------------------------------------------
  spg_pwd_store #(
    .NV_WRITE_CYCLES (NV_WRITE_CYCLES)
  ) u_pwd_store (
    .clk (clk),
    .rst (rst),
    .pif (pif.store)
  );

  // Rights follow the guard bytes and password state with no delay
  for (genvar s = 0; s < SECTORS; s++) begin : g_rights
    spg_rights_decode u_dec (
      .guard     (guard_reg[s]),
      .presented (pres_reg),
      .rd_ok     (rd_ok[s]),
      .wr_ok     (wr_ok[s])
    );
  end

  // Block address to sector; every block of a sector shares its guard byte
  assign sector  = rf_block_addr[8:`SPG_BLOCK_SHIFT];
  assign i2c_hit = chip_enable_select_bit
                   && (i2c_byte_addr < 11'(`SPG_GUARD_AREA_BYTES));
  assign rf_take = rf_cmd_valid && (state_reg == SPG_ST_IDLE);

  // --------------------------------------------------------------------------
  // Command decode and next state
  // --------------------------------------------------------------------------
  // Two-wire guard write is applied after the contactless update, so it wins
  always_comb begin
    state_next     = state_reg;
    guard_next     = guard_reg;
    pres_next      = pres_reg;
    rsp_valid_next = 1'b0;
    rsp_error_next = 1'b0;
    gvalid_next    = 1'b0;
    gbyte_next     = gbyte_reg;
    maddr_next     = maddr_reg;
    mrd_next       = 1'b0;
    mwr_next       = 1'b0;
    pif.wr_start   = 1'b0;
    pif.wr_slot    = rf_pwd_slot;
    pif.wr_data    = rf_cmd_data;
    case (state_reg)
      SPG_ST_IDLE: begin
        if (rf_cmd_valid) begin
          rsp_valid_next = 1'b1;
          maddr_next     = {rf_block_addr, 2'b00};
          case (rf_cmd_op)
            SPG_OP_READ: begin
              if (rd_ok[sector]) begin
                mrd_next    = 1'b1;
                gvalid_next = rf_option_flag;
                gbyte_next  = guard_reg[sector];
              end else begin
                rsp_error_next = 1'b1;
              end
            end
            SPG_OP_WRITE: begin
              if (wr_ok[sector]) begin
                mwr_next = 1'b1;
              end else begin
                rsp_error_next = 1'b1;
              end
            end
            SPG_OP_LOCK: begin
              if (guard_reg[rf_lock_sector][`SPG_GUARD_LOCK_BIT]) begin
                rsp_error_next = 1'b1;
              end else begin
                guard_next[rf_lock_sector] = {3'b000, rf_cmd_data[4:1], 1'b1};
              end
            end
            SPG_OP_PWD_WRITE: begin
              if ((rf_pwd_slot == 2'b00) || !pres_reg[rf_pwd_slot]) begin
                rsp_error_next = 1'b1;
              end else begin
                pif.wr_start   = 1'b1;
                rsp_valid_next = 1'b0;
                state_next     = SPG_ST_PWD_WAIT;
              end
            end
            SPG_OP_PWD_PRESENT: begin
              if (rf_pwd_slot == 2'b00) begin
                rsp_error_next = 1'b1;
              end else if (pif.value[rf_pwd_slot] == rf_cmd_data) begin
                pres_next = 3'b000;
                pres_next[rf_pwd_slot] = 1'b1;
              end else begin
                pres_next      = 3'b000;
                rsp_error_next = 1'b1;
              end
            end
            default: begin
              rsp_error_next = 1'b1;
            end
          endcase
        end
      end
      SPG_ST_PWD_WAIT: begin
        // Answer only once the new value is in use
        if (pif.wr_done) begin
          rsp_valid_next = 1'b1;
          state_next     = SPG_ST_IDLE;
        end
      end
      default: begin
        state_next = SPG_ST_IDLE;
      end
    endcase
    // Host write replaces the whole condition of that sector
    if (i2c_req_valid && i2c_req_write && i2c_hit && i2c_pwd_accepted) begin
      guard_next[i2c_byte_addr[3:0]] = {3'b000, i2c_wdata[4:0]};
    end
    ready_next = (state_next == SPG_ST_IDLE);
  end

  // Two-wire answer: reads in the guard area always served, writes refused without password
  always_comb begin
    i2c_valid_next = i2c_req_valid;
    i2c_ref_next   = 1'b0;
    i2c_rdata_next = 8'h00;
    if (i2c_req_valid) begin
      if (!i2c_hit || (i2c_req_write && !i2c_pwd_accepted)) begin
        i2c_ref_next = 1'b1;
      end else if (!i2c_req_write) begin
        i2c_rdata_next = {3'b000, guard_reg[i2c_byte_addr[3:0]][4:0]};
      end
    end
  end

  // --------------------------------------------------------------------------
  // Registers
  // --------------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      state_reg <= SPG_ST_IDLE;
      for (int i = 0; i < SECTORS; i++) begin
        guard_reg[i] <= `SPG_GUARD_RESET;
      end
      pres_reg      <= 3'b000;
      ready_reg     <= 1'b0;
      rsp_valid_reg <= 1'b0;
      rsp_error_reg <= 1'b0;
      gvalid_reg    <= 1'b0;
      gbyte_reg     <= 8'h00;
      maddr_reg     <= 11'h000;
      mrd_reg       <= 1'b0;
      mwr_reg       <= 1'b0;
      i2c_valid_reg <= 1'b0;
      i2c_ref_reg   <= 1'b0;
      i2c_rdata_reg <= 8'h00;
    end else begin
      state_reg     <= state_next;
      guard_reg     <= guard_next;
      pres_reg      <= pres_next;
      ready_reg     <= ready_next;
      rsp_valid_reg <= rsp_valid_next;
      rsp_error_reg <= rsp_error_next;
      gvalid_reg    <= gvalid_next;
      gbyte_reg     <= gbyte_next;
      maddr_reg     <= maddr_next;
      mrd_reg       <= mrd_next;
      mwr_reg       <= mwr_next;
      i2c_valid_reg <= i2c_valid_next;
      i2c_ref_reg   <= i2c_ref_next;
      i2c_rdata_reg <= i2c_rdata_next;
    end
  end

  // Outputs straight from flip-flops
  assign rf_cmd_ready       = ready_reg;
  assign rf_rsp_valid       = rsp_valid_reg;
  assign rf_rsp_error       = rsp_error_reg;
  assign rf_rsp_guard_valid = gvalid_reg;
  assign rf_rsp_guard_byte  = gbyte_reg;
  assign rf_mem_byte_addr   = maddr_reg;
  assign rf_mem_read        = mrd_reg;
  assign rf_mem_write       = mwr_reg;
  assign i2c_rsp_valid      = i2c_valid_reg;
  assign i2c_rsp_refused    = i2c_ref_reg;
  assign i2c_rdata          = i2c_rdata_reg;

  // --------------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  chk_lock_sets_bits: assert property (
    (rf_take && rf_cmd_op == SPG_OP_LOCK && !guard_reg[rf_lock_sector][0] && !i2c_req_valid)
    |=> guard_reg[$past(rf_lock_sector)] == {3'b000, $past(rf_cmd_data[4:1]), 1'b1})
    else $error("lock did not set guard byte");

  chk_relock_error: assert property (
    (rf_take && rf_cmd_op == SPG_OP_LOCK && guard_reg[rf_lock_sector][0])
    |=> rf_rsp_valid && rf_rsp_error)
    else $error("relock of locked sector not refused");

  chk_read_denied: assert property (
    (rf_take && rf_cmd_op == SPG_OP_READ && !rd_ok[sector])
    |=> rf_rsp_error && !rf_mem_read && !rf_rsp_guard_valid)
    else $error("read of protected sector allowed");

  chk_unlocked_open: assert property (
    (rf_take && (rf_cmd_op == SPG_OP_READ || rf_cmd_op == SPG_OP_WRITE)
     && !guard_reg[sector][0])
    |=> !rf_rsp_error && (rf_mem_read || rf_mem_write))
    else $error("unlocked sector access refused");

  chk_guard_reply: assert property (
    (rf_take && rf_cmd_op == SPG_OP_READ && rd_ok[sector] && rf_option_flag)
    |=> rf_rsp_guard_valid && rf_rsp_guard_byte == $past(guard_reg[sector]))
    else $error("guard byte not returned with read");

  chk_bad_pwd_clears: assert property (
    (rf_take && rf_cmd_op == SPG_OP_PWD_PRESENT && rf_pwd_slot != 2'b00
     && pif.value[rf_pwd_slot] != rf_cmd_data)
    |=> pres_reg == 3'b000 && rf_rsp_error)
    else $error("wrong password left rights active");

  chk_pwd_write_guard: assert property (
    (rf_take && rf_cmd_op == SPG_OP_PWD_WRITE && !pres_reg[rf_pwd_slot])
    |=> rf_rsp_error && state_reg == SPG_ST_IDLE && !pif.busy)
    else $error("password changed without presentation");

  chk_i2c_write_lock: assert property (
    (i2c_req_valid && i2c_req_write && !i2c_pwd_accepted)
    |=> i2c_rsp_valid && i2c_rsp_refused)
    else $error("host guard write not refused");

  chk_i2c_read_open: assert property (
    (i2c_req_valid && !i2c_req_write && i2c_hit)
    |=> !i2c_rsp_refused && i2c_rdata[7:5] == 3'b000
        && i2c_rdata[4:0] == $past(guard_reg[i2c_byte_addr[3:0]][4:0]))
    else $error("host guard read wrong or refused");
endmodule

// ---- spg_sector_guard_bench.sv ----
// Self-checking bench of the sector access guard
`timescale 1ns/1ps
module spg_sector_guard_bench;
  import spg_pkg::*;
  localparam int unsigned NVW = 8;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        rf_cmd_valid, rf_option_flag, rf_cmd_ready, rf_rsp_valid, rf_rsp_error;
  logic        rf_rsp_guard_valid, rf_mem_read, rf_mem_write, i2c_req_valid;
  logic        i2c_req_write, chip_enable_select_bit, i2c_pwd_accepted;
  logic        i2c_rsp_valid, i2c_rsp_refused;
  spg_rf_op_t  rf_cmd_op;
  logic [8:0]  rf_block_addr;
  logic [3:0]  rf_lock_sector;
  logic [1:0]  rf_pwd_slot;
  logic [31:0] rf_cmd_data;
  logic [7:0]  rf_rsp_guard_byte, i2c_wdata, i2c_rdata;
  logic [10:0] rf_mem_byte_addr, i2c_byte_addr;
  int          fails = 0;
  int          cmp_count = 0;
  int          cyc = 0;
  bit          seen;

  spg_sector_guard #(.NV_WRITE_CYCLES(NVW), .SECTORS(16)) u_dut (
    .clk(clk), .rst(rst), .rf_cmd_valid(rf_cmd_valid), .rf_cmd_op(rf_cmd_op),
    .rf_block_addr(rf_block_addr), .rf_option_flag(rf_option_flag),
    .rf_lock_sector(rf_lock_sector), .rf_pwd_slot(rf_pwd_slot), .rf_cmd_data(rf_cmd_data),
    .rf_cmd_ready(rf_cmd_ready), .rf_rsp_valid(rf_rsp_valid), .rf_rsp_error(rf_rsp_error),
    .rf_rsp_guard_valid(rf_rsp_guard_valid), .rf_rsp_guard_byte(rf_rsp_guard_byte),
    .rf_mem_byte_addr(rf_mem_byte_addr), .rf_mem_read(rf_mem_read),
    .rf_mem_write(rf_mem_write), .i2c_req_valid(i2c_req_valid),
    .i2c_req_write(i2c_req_write), .chip_enable_select_bit(chip_enable_select_bit),
    .i2c_byte_addr(i2c_byte_addr), .i2c_wdata(i2c_wdata),
    .i2c_pwd_accepted(i2c_pwd_accepted), .i2c_rsp_valid(i2c_rsp_valid),
    .i2c_rsp_refused(i2c_rsp_refused), .i2c_rdata(i2c_rdata));

  spg_reader_model u_rdr (
    .clk(clk), .rf_cmd_valid(rf_cmd_valid), .rf_cmd_op(rf_cmd_op),
    .rf_block_addr(rf_block_addr), .rf_option_flag(rf_option_flag),
    .rf_lock_sector(rf_lock_sector), .rf_pwd_slot(rf_pwd_slot), .rf_cmd_data(rf_cmd_data),
    .rf_cmd_ready(rf_cmd_ready), .rf_rsp_valid(rf_rsp_valid),
    .i2c_req_valid(i2c_req_valid), .i2c_req_write(i2c_req_write),
    .chip_enable_select_bit(chip_enable_select_bit), .i2c_byte_addr(i2c_byte_addr),
    .i2c_wdata(i2c_wdata), .i2c_pwd_accepted(i2c_pwd_accepted),
    .i2c_rsp_valid(i2c_rsp_valid));

  // ---------------------------------------------------------------------------
  // Clock, hang guard and comparisons
  // ---------------------------------------------------------------------------
  always #50 clk = ~clk;

  // Real run is about 150 cycles; far past that means a stuck handshake
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      fails++;
      complete_run();
    end
  end

  task automatic cmp_bit(input logic got, input logic exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH t=%0t %s got %b exp %b", $time, what, got, exp);
    end
  endtask

  task automatic cmp_val(input logic [10:0] got, input logic [10:0] exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic complete_run();
    $display("Compares %0d, mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // Fresh part: every guard byte clear, last block of the map readable with its guard byte
  task automatic t_fresh();
    for (int k = 0; k < 16; k++) begin
      u_rdr.i2c(1'b0, 1'b1, 11'(k), 8'h00, 1'b0, seen);
      cmp_bit(seen & ~i2c_rsp_refused, 1'b1, "guard read");
      cmp_val({3'h0, i2c_rdata}, 11'h000, "guard reset");
    end
    u_rdr.rf(SPG_OP_READ, 9'h1ff, 1'b1, 4'h0, 2'h0, 32'h0, seen);
    cmp_bit(rf_mem_read & rf_rsp_guard_valid, 1'b1, "open read");
    cmp_val(rf_mem_byte_addr, 11'h7fc, "byte address");
  endtask

  // Host refusals: wrong select bit, outside the area, no host password
  task automatic t_host_refuse();
    u_rdr.i2c(1'b0, 1'b0, 11'h001, 8'h00, 1'b1, seen);
    cmp_bit(i2c_rsp_refused, 1'b1, "select bit low");
    u_rdr.i2c(1'b0, 1'b1, 11'h010, 8'h00, 1'b1, seen);
    cmp_bit(i2c_rsp_refused, 1'b1, "past area");
    u_rdr.i2c(1'b1, 1'b1, 11'h004, 8'h1f, 1'b0, seen);
    cmp_bit(i2c_rsp_refused, 1'b1, "write no host password");
    u_rdr.i2c(1'b0, 1'b1, 11'h004, 8'h00, 1'b0, seen);
    cmp_val({3'h0, i2c_rdata}, 11'h000, "byte kept");
  endtask

  // Every protection code, with and without the linked password
  task automatic t_codes();
    logic [7:0] g;
    logic       rd_ok;
    logic       wr_ok;
    for (int c = 0; c < 4; c++) begin
      g = {3'b000, 2'b10, 2'(c), 1'b1};
      u_rdr.i2c(1'b1, 1'b1, 11'h003, g | 8'he0, 1'b1, seen);
      u_rdr.i2c(1'b0, 1'b1, 11'h003, 8'h00, 1'b1, seen);
      cmp_val({3'h0, i2c_rdata}, {3'h0, g}, "guard rewrite");
      for (int p = 0; p < 2; p++) begin
        u_rdr.rf(SPG_OP_PWD_PRESENT, 9'h000, 1'b0, 4'h0, 2'h2, 32'(1 - p), seen);
        cmp_bit(rf_rsp_error, p == 0, "present result");
        rd_ok = p == 1 || c < 2;
        wr_ok = (p == 1) ? c != 3 : c == 1;
        u_rdr.rf(SPG_OP_READ, 9'h07f, 1'b1, 4'h0, 2'h0, 32'h0, seen);
        cmp_bit(rf_mem_read, rd_ok, "locked read");
        cmp_val({2'h0, rf_rsp_guard_valid, rd_ok ? rf_rsp_guard_byte : g},
                {2'h0, rd_ok, g}, "guard with data");
        u_rdr.rf(SPG_OP_WRITE, 9'h060, 1'b0, 4'h0, 2'h0, 32'h0, seen);
        cmp_bit(rf_mem_write, wr_ok, "locked write");
      end
    end
  endtask

  // Lock over the air, relock refused, grant then withdrawal, password change
  task automatic t_lock_pwd();
    u_rdr.rf(SPG_OP_LOCK, 9'h000, 1'b0, 4'h5, 2'h0, 32'h0000_000e, seen);
    u_rdr.i2c(1'b0, 1'b1, 11'h005, 8'h00, 1'b0, seen);
    cmp_val({3'h0, i2c_rdata}, 11'h00f, "lock byte");
    u_rdr.rf(SPG_OP_LOCK, 9'h000, 1'b0, 4'h5, 2'h0, 32'h0000_0002, seen);
    cmp_bit(seen & rf_rsp_error, 1'b1, "relock");
    u_rdr.rf(SPG_OP_PWD_PRESENT, 9'h000, 1'b0, 4'h0, 2'h1, 32'h0, seen);
    u_rdr.rf(SPG_OP_READ, 9'h0bf, 1'b0, 4'h0, 2'h0, 32'h0, seen);
    cmp_bit(rf_mem_read, 1'b1, "granted read");
    u_rdr.rf(SPG_OP_PWD_PRESENT, 9'h000, 1'b0, 4'h0, 2'h3, 32'h5, seen);
    u_rdr.rf(SPG_OP_READ, 9'h0a0, 1'b0, 4'h0, 2'h0, 32'h0, seen);
    cmp_bit(rf_rsp_error, 1'b1, "withdrawn read");
    u_rdr.rf(SPG_OP_PWD_WRITE, 9'h000, 1'b0, 4'h0, 2'h1, 32'h1234_5678, seen);
    cmp_bit(rf_rsp_error, 1'b1, "change unpresented");
    u_rdr.rf(SPG_OP_PWD_PRESENT, 9'h000, 1'b0, 4'h0, 2'h1, 32'h0, seen);
    cmp_bit(rf_rsp_error, 1'b0, "zero password");
    u_rdr.rf(SPG_OP_PWD_WRITE, 9'h000, 1'b0, 4'h0, 2'h1, 32'h1234_5678, seen);
    cmp_bit(seen & ~rf_rsp_error, 1'b1, "change done");
    cmp_bit(rf_cmd_ready, 1'b1, "ready after change");
    u_rdr.rf(SPG_OP_PWD_PRESENT, 9'h000, 1'b0, 4'h0, 2'h1, 32'h0, seen);
    cmp_bit(rf_rsp_error, 1'b1, "old value");
    u_rdr.rf(SPG_OP_PWD_PRESENT, 9'h000, 1'b0, 4'h0, 2'h1, 32'h1234_5678, seen);
    cmp_bit(rf_rsp_error, 1'b0, "new value");
  endtask

  // Main sequence
  initial begin
    repeat (12) @(negedge clk);
    rst = 1'b0;
    repeat (2) @(negedge clk);
    t_fresh();
    t_host_refuse();
    t_codes();
    t_lock_pwd();
    complete_run();
  end
endmodule
